// File: fip_defines.vh
// constants for the flash identification and protection host controller
// Summary of operation
// RULE1: device drives identifier codes in identification mode
// RULE2: host holds select line elevated, A6 low
// RULE3: A1A0=00 maker code, 01 device code
// RULE4: A1A0=10 with group address returns 80h/00h
// RULE5: A1A0=11 returns 90h or 10h indicator
// RULE6: identification also reachable by command sequence
// RULE7: protected groups refuse program and erase
// RULE8: group is four sectors, index A22-A18
// RULE9: host protects all groups before unprotect
// RULE10: only reset pin needs elevated level
// RULE11: groups ship unprotected
// RULE12: elevated reset temporarily unprotects groups
// RULE13: separate 256-byte region via enter command
// RULE14: lock indicator fixed, 1 factory locked
// RULE15: enter command overlays first sector until exit
// RULE16: reset or power-up maps first sector normally
// RULE17: factory part holds 16-byte serial, read-only
// RULE18: customer part region writable
// RULE19: refused operation leaves array, reads array
// RULE20: host issues exit after region lock/verify
`ifndef FIP_DEFINES_VH
`define FIP_DEFINES_VH
`define FIP_ADDR_W        23
`define FIP_GROUP_LSB     18
`define FIP_GROUP_MSB     22
`define FIP_SEL_MAKER     2'h0
`define FIP_SEL_DEVICE    2'h1
`define FIP_SEL_PROTECT   2'h2
`define FIP_SEL_LOCK      2'h3
`define FIP_PROT_YES      8'h80
`define FIP_PROT_NO       8'h00
`define FIP_LOCK_FACTORY  8'h90
`define FIP_LOCK_CUSTOMER 8'h10
`define FIP_LOCK_BIT      7
`define FIP_UNLOCK1_ADDR  23'h000AAA
`define FIP_UNLOCK2_ADDR  23'h000555
`define FIP_UNLOCK1_DATA  8'hAA
`define FIP_UNLOCK2_DATA  8'h55
`define FIP_CMD_AUTOSEL   8'h90
`define FIP_CMD_ENTER     8'h88
`define FIP_CMD_EXIT      8'h90
`define FIP_CMD_EXIT2     8'h00
`define FIP_CMD_RESET     8'hF0
`define FIP_ACCESS_NS     120
`define FIP_ACCESS_CYC    (((`FIP_ACCESS_NS) * 10 + 999) / 1000)
`define FIP_PULSE_NS      50
`define FIP_PULSE_CYC     (((`FIP_PULSE_NS) * 10 + 999) / 1000)
`endif

// File: fip_bus_cycle.v
// one asynchronous read or write cycle on the flash parallel bus
`timescale 1ns/1ps
`default_nettype none
`include "fip_defines.vh"
module fip_bus_cycle #(
	parameter HOLD_CYC = 2
)(
	input  wire                   mclk,
	input  wire                   reset,
	input  wire                   start,
	input  wire                   write,
	input  wire [`FIP_ADDR_W-1:0] addr,
	input  wire [7:0]             wdata,
	input  wire [7:0]             data_in_sync,
	output reg                    busy,
	output reg                    done,
	output reg  [7:0]             rdata,
	output reg  [`FIP_ADDR_W-1:0] addr_pin,
	output reg  [7:0]             data_out,
	output reg                    data_oe,
	output reg                    chip_en_n,
	output reg                    out_en_n,
	output reg                    write_en_n
);
	// extra two cycles cover the input synchroniser delay on reads
	localparam integer LAST_I = HOLD_CYC + 2;
	localparam [7:0] LAST = LAST_I[7:0];
	reg [7:0] cnt;
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			addr_pin <= {`FIP_ADDR_W{1'b0}};
			data_out <= 8'h00;
			data_oe <= 1'b0;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			write_en_n <= 1'b1;
			cnt <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			if (!busy && start)
			begin
				busy <= 1'b1;
				cnt <= 8'h00;
				addr_pin <= addr;
				data_out <= wdata;
				data_oe <= write;
				chip_en_n <= 1'b0;
				out_en_n <= write;
				write_en_n <= !write;
			end
			else if (busy)
			begin
				cnt <= cnt + 8'h01;
				if (cnt == LAST)
				begin
					// strobes rise together; data stays driven one more cycle for hold
					rdata <= data_in_sync;
					chip_en_n <= 1'b1;
					out_en_n <= 1'b1;
					write_en_n <= 1'b1;
				end
				else if (cnt == LAST + 8'h01)
				begin
					data_oe <= 1'b0;
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: fip_host.v
// host controller for flash identification, group protection status and secure region access
`timescale 1ns/1ps
`default_nettype none
`include "fip_defines.vh"
module fip_host (
	input  wire                   mclk,
	input  wire                   reset,
	input  wire                   req,
	input  wire [2:0]             op,
	input  wire [4:0]             group_in,
	input  wire [`FIP_ADDR_W-1:0] addr_in,
	input  wire [7:0]             wdata_in,
	input  wire                   hv_method,
	input  wire                   temp_unprotect,
	input  wire [7:0]             data_lines_in,
	output reg                    busy,
	output reg                    done,
	output reg  [7:0]             result,
	output reg                    protected_flag,
	output reg                    factory_locked,
	output reg                    region_active,
	output reg  [`FIP_ADDR_W-1:0] addr_pin,
	output reg  [7:0]             data_lines_out,
	output reg                    data_lines_oe,
	output reg                    chip_en_n,
	output reg                    out_en_n,
	output reg                    write_en_n,
	output reg                    elevated_select_level,
	output reg                    reset_elevated,
	output reg                    flash_reset_n
);
	// operations requested by the user side
	localparam [2:0] OP_ID_MAKER   = 3'h0;
	localparam [2:0] OP_ID_DEVICE  = 3'h1;
	localparam [2:0] OP_ID_PROTECT = 3'h2; // RULE4
	localparam [2:0] OP_ID_LOCK    = 3'h3;
	localparam [2:0] OP_ENTER      = 3'h4;
	localparam [2:0] OP_EXIT       = 3'h5;
	localparam [2:0] OP_READ       = 3'h6;
	localparam [2:0] OP_HWRESET    = 3'h7;
	// one-hot states
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_SEQ  = 6'h02;
	localparam [5:0] ST_WAIT = 6'h04;
	localparam [5:0] ST_RST  = 6'h08;
	localparam [5:0] ST_DONE = 6'h10;
	localparam [5:0] ST_HOLD = 6'h20;
	localparam integer RST_CYC_I = `FIP_PULSE_CYC + 1;
	localparam [7:0] RST_CYC = RST_CYC_I[7:0];
	reg [5:0]             state;
	reg [2:0]             cur_op;
	reg [2:0]             step;
	reg [2:0]             last_step;
	reg [7:0]             rst_cnt;
	reg [`FIP_ADDR_W-1:0] op_addr;
	reg                   cyc_start;
	reg                   cyc_write;
	reg [`FIP_ADDR_W-1:0] cyc_addr;
	reg [7:0]             cyc_data;
	reg [7:0]             data_meta;
	reg [7:0]             data_sync;
	wire                  cyc_done;
	wire [7:0]            cyc_rdata;
	wire [`FIP_ADDR_W-1:0] pin_addr;
	wire [7:0]            pin_dout;
	wire                  pin_oe;
	wire                  pin_ce_n;
	wire                  pin_oe_n;
	wire                  pin_we_n;

	// data pins come from the flash, outside our clock
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			data_meta <= 8'h00;
			data_sync <= 8'h00;
		end
		else
		begin
			data_meta <= data_lines_in;
			data_sync <= data_meta;
		end
	end

	fip_bus_cycle #(
		.HOLD_CYC (`FIP_ACCESS_CYC)
	) u_cycle (
		.mclk         (mclk),
		.reset        (reset),
		.start        (cyc_start),
		.write        (cyc_write),
		.addr         (cyc_addr),
		.wdata        (cyc_data),
		.data_in_sync (data_sync),
		.busy         (),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.addr_pin     (pin_addr),
		.data_out     (pin_dout),
		.data_oe      (pin_oe),
		.chip_en_n    (pin_ce_n),
		.out_en_n     (pin_oe_n),
		.write_en_n   (pin_we_n)
	);
	// register the pins again so every top output is a flop
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			addr_pin <= {`FIP_ADDR_W{1'b0}};
			data_lines_out <= 8'h00;
			data_lines_oe <= 1'b0;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			write_en_n <= 1'b1;
		end
		else
		begin
			addr_pin <= pin_addr;
			data_lines_out <= pin_dout;
			data_lines_oe <= pin_oe;
			chip_en_n <= pin_ce_n;
			out_en_n <= pin_oe_n;
			write_en_n <= pin_we_n;
		end
	end

	// identification read address: group on top bits, A6 low, A1A0 pick the code
	function [`FIP_ADDR_W-1:0] id_addr;
		input [4:0] grp;
		input [1:0] sel;
		begin
			id_addr = {`FIP_ADDR_W{1'b0}};
			id_addr[`FIP_GROUP_MSB:`FIP_GROUP_LSB] = grp; // RULE4 RULE8
			id_addr[6] = 1'b0; // RULE2
			id_addr[1:0] = sel; // RULE3
		end
	endfunction

	// sequence table: steps 0..1 unlock writes, step 2 a command, step 3 id read or exit zero write, step 4 reset write, step 5 lone read
	always @*
	begin
		cyc_write = 1'b1;
		cyc_addr = `FIP_UNLOCK1_ADDR;
		cyc_data = `FIP_UNLOCK1_DATA;
		case (step)
			3'h1:
			begin
				cyc_addr = `FIP_UNLOCK2_ADDR;
				cyc_data = `FIP_UNLOCK2_DATA;
			end
			3'h2:
			begin
				if (cur_op == OP_ENTER)
					cyc_data = `FIP_CMD_ENTER; // RULE13
				else if (cur_op == OP_EXIT)
					cyc_data = `FIP_CMD_EXIT; // RULE20
				else
					cyc_data = `FIP_CMD_AUTOSEL; // RULE6
			end
			3'h3:
			begin
				// exit needs a trailing zero write; id ops read here
				cyc_write = (cur_op == OP_EXIT);
				cyc_addr = (cur_op == OP_EXIT) ? {`FIP_ADDR_W{1'b0}} : op_addr;
				cyc_data = `FIP_CMD_EXIT2;
			end
			3'h4:
			begin
				// leave identification mode so array reads resume
				cyc_data = `FIP_CMD_RESET;
			end
			default:
			begin
				cyc_write = (step == 3'h0); // step 0 is the first unlock write, step 5 the lone read
				cyc_addr = (step == 3'h0) ? `FIP_UNLOCK1_ADDR : op_addr;
			end
		endcase
	end

	// main sequencer
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			cur_op <= OP_ID_MAKER;
			step <= 3'h0;
			last_step <= 3'h0;
			rst_cnt <= 8'h00;
			op_addr <= {`FIP_ADDR_W{1'b0}};
			cyc_start <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			result <= 8'h00;
			protected_flag <= 1'b0;
			factory_locked <= 1'b0;
			region_active <= 1'b0; // RULE16
			elevated_select_level <= 1'b0;
			reset_elevated <= 1'b0;
			flash_reset_n <= 1'b0;
		end
		else
		begin
			cyc_start <= 1'b0;
			done <= 1'b0;
			flash_reset_n <= 1'b1;
			// elevated reset is the only high level for protection work
			reset_elevated <= temp_unprotect; // RULE10 RULE12
			case (state)
				ST_IDLE:
				begin
					if (req)
					begin
						busy <= 1'b1;
						cur_op <= op;
						op_addr <= (op == OP_READ) ? addr_in : id_addr(group_in, op[1:0]);
						if (op == OP_HWRESET)
						begin
							rst_cnt <= 8'h00;
							state <= ST_RST;
						end
						else if (op == OP_READ || (op[2] == 1'b0 && hv_method))
						begin
							// programming-equipment path and plain array reads: single read, no commands
							elevated_select_level <= !op[2]; // RULE2
							step <= 3'h5;
							last_step <= 3'h5;
							state <= ST_HOLD;
						end
						else
						begin
							step <= 3'h0;
							last_step <= (op[2] == 1'b0) ? 3'h4 : ((op == OP_EXIT) ? 3'h3 : 3'h2);
							state <= ST_SEQ;
						end
					end
				end
				ST_HOLD:
				begin
					// give the select level one cycle to settle before the read
					state <= ST_SEQ;
				end
				ST_SEQ:
				begin
					cyc_start <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (cyc_done)
					begin
						if (step == 3'h3 && cur_op[2] == 1'b0 || step == 3'h5)
							result <= cyc_rdata; // RULE1
						if (step == last_step)
							state <= ST_DONE;
						else
						begin
							step <= step + 3'h1;
							state <= ST_SEQ;
						end
					end
				end
				ST_RST:
				begin
					flash_reset_n <= 1'b0;
					rst_cnt <= rst_cnt + 8'h01;
					if (rst_cnt == RST_CYC)
					begin
						region_active <= 1'b0; // RULE16
						state <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					elevated_select_level <= 1'b0;
					busy <= 1'b0;
					done <= 1'b1;
					if (cur_op == OP_ENTER)
						region_active <= 1'b1; // RULE15
					if (cur_op == OP_EXIT)
						region_active <= 1'b0; // RULE20
					if (cur_op == OP_ID_PROTECT)
						protected_flag <= (result == `FIP_PROT_YES); // RULE4
					if (cur_op == OP_ID_LOCK)
						factory_locked <= result[`FIP_LOCK_BIT]; // RULE5 RULE14
					state <= ST_IDLE;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: fip_host_chk.sv
// port checker for the flash identification host
`timescale 1ns/1ps
`default_nettype none
`include "fip_defines.vh"
module fip_host_chk (
	input wire logic	mclk,
	input wire logic	reset,
	input wire logic	req,
	input wire logic [2:0]	op,
	input wire logic [4:0]	group_in,
	input wire logic	hv_method,
	input wire logic	temp_unprotect,
	input wire logic	busy,
	input wire logic	done,
	input wire logic [7:0]	result,
	input wire logic	protected_flag,
	input wire logic	factory_locked,
	input wire logic	region_active,
	input wire logic [22:0]	addr_pin,
	input wire logic	data_lines_oe,
	input wire logic	out_en_n,
	input wire logic	write_en_n,
	input wire logic	elevated_select_level,
	input wire logic	reset_elevated,
	input wire logic	flash_reset_n
);
	logic [2:0]	op_q;
	logic [4:0]	grp_q;
	wire logic	take = req && !busy;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// request seen at acceptance, held for the whole operation
	always @(posedge mclk or posedge reset)
		if (reset)
		begin
			op_q <= 3'h0;
			grp_q <= 5'h00;
		end
		else if (take)
		begin
			op_q <= op;
			grp_q <= group_in;
		end
	rw_apart_a: assert property (out_en_n || write_en_n) else $error("strobes overlap");
	no_drive_a: assert property (!out_en_n |-> !data_lines_oe) else $error("bus fight");
	hv_read_a: assert property (elevated_select_level && !out_en_n |-> !addr_pin[6] && write_en_n)
		else $error("bad hv read");
	hv_raise_a: assert property (take && hv_method && op < 3'h4 |-> ##[1:4] elevated_select_level)
		else $error("no hv");
	grp_addr_a: assert property (busy && op_q == 3'h2 && !out_en_n |->
		addr_pin[22:18] == grp_q && addr_pin[1:0] == 2'h2) else $error("bad group addr");
	temp_hv_a: assert property (reset_elevated == $past(temp_unprotect)) else $error("hv reset lag");
	op_done_a: assert property (take |-> ##[1:80] done ##1 !done) else $error("no done");
	prot_flag_a: assert property (done && op_q == 3'h2 |=> protected_flag == (result == 8'h80))
		else $error("prot flag");
	lock_flag_a: assert property (done && op_q == 3'h3 |=> factory_locked == result[7])
		else $error("lock flag");
	reg_set_a: assert property (done && op_q == 3'h4 |=> region_active) else $error("no region");
	reg_clr_a: assert property (done && (op_q == 3'h5 || op_q == 3'h7) |=> !region_active)
		else $error("region stuck");
	hw_rst_a: assert property (take && op == 3'h7 |-> ##[1:10] !flash_reset_n) else $error("no pulse");
endmodule
bind fip_host fip_host_chk u_chk (.mclk, .reset, .req, .op, .group_in, .hv_method, .temp_unprotect,
	.busy, .done, .result, .protected_flag, .factory_locked, .region_active, .addr_pin, .data_lines_oe,
	.out_en_n, .write_en_n, .elevated_select_level, .reset_elevated, .flash_reset_n);
`default_nettype wire

// File: fip_flash_model.sv
// behavioural flash answering identification and secure region reads
`timescale 1ns/1ps
`default_nettype none
module fip_flash_model #(
	parameter [7:0]	MAKER_CODE = 8'h3C, // arbitrary value
	parameter [7:0]	DEVICE_CODE = 8'hC3, // arbitrary value
	parameter	FACTORY = 1,
	parameter [31:0]	PROT_INIT = 32'h0,
	parameter [7:0]	SER_SEED = 8'hA0
)(
	input wire logic [22:0]	addr,
	input wire logic [7:0]	din,
	input wire logic	ce_n,
	input wire logic	oe_n,
	input wire logic	we_n,
	input wire logic	elev,
	input wire logic	rst_n,
	output logic [7:0]	q
);
	logic [7:0]	s1, s2, val;
	logic [7:0]	last = 8'h00;
	logic	id_mode, in_region;
	wire logic	unl = s2 == 8'hAA && s1 == 8'h55;
	// commands land on the write strobe's rising edge
	always @(posedge we_n or negedge rst_n)
		if (!rst_n)
		begin
			id_mode <= 1'b0;
			in_region <= 1'b0;
			s1 <= 8'h00;
			s2 <= 8'h00;
		end
		else
		begin
			if (unl && din == 8'h90) id_mode <= 1'b1;
			if (unl && din == 8'h88) in_region <= 1'b1;
			if (din == 8'hF0) id_mode <= 1'b0;
			if (din == 8'h00 && id_mode)
			begin
				id_mode <= 1'b0;
				in_region <= 1'b0;
			end
			s2 <= s1;
			s1 <= din;
		end
	// released bus shows the inverse of the last byte, never a held value
	always @*
	begin
		if (id_mode || (elev && !addr[6]))
			case (addr[1:0])
				2'h0: val = MAKER_CODE;
				2'h1: val = DEVICE_CODE;
				2'h2: val = PROT_INIT[addr[22:18]] ? 8'h80 : 8'h00;
				default: val = FACTORY ? 8'h90 : 8'h10;
			endcase
		else if (in_region && addr[22:16] == 7'h00)
			val = addr[15:4] == 12'h000 ? SER_SEED ^ addr[7:0] : 8'hFF;
		else
			val = addr[7:0];
		q = (!ce_n && !oe_n) ? val : ~last;
	end
	always @(posedge oe_n) last <= val;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the flash identification host
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
	localparam [7:0] MK = 8'h3C;
	localparam [7:0] DV = 8'hC3;
	localparam [7:0] SD = 8'hA0;
	logic	mclk = 0, reset = 1, req = 0, hv_method = 0, temp_unprotect = 0;
	logic [2:0]	op = 0;
	logic [4:0]	group_in = 0;
	logic [22:0]	addr_in = 0;
	logic [7:0]	wdata_in = 0;
	wire logic [22:0]	addr_pin;
	wire logic [7:0]	result, data_lines_out, mq, bus;
	wire logic	busy, done, protected_flag, factory_locked, region_active, data_lines_oe;
	wire logic	chip_en_n, out_en_n, write_en_n, elevated_select_level, reset_elevated, flash_reset_n;
	integer	err_count = 0, cmp_count = 0, cyc = 0, i;
	// op, group, hv method, expected byte
	logic [16:0] rows [11] = '{{3'h0, 5'h00, 1'b1, MK}, {3'h1, 5'h00, 1'b1, DV}, {3'h2, 5'h00, 1'b1, 8'h80},
		{3'h2, 5'h01, 1'b1, 8'h00}, {3'h3, 5'h00, 1'b1, 8'h90}, {3'h0, 5'h00, 1'b0, MK}, {3'h1, 5'h00, 1'b0, DV},
		{3'h2, 5'h02, 1'b0, 8'h80}, {3'h2, 5'h1F, 1'b0, 8'h00}, {3'h3, 5'h00, 1'b0, 8'h90}, {3'h6, 5'h00, 1'b0, 8'h12}};
	assign bus = data_lines_oe ? data_lines_out : mq;
	always #50 mclk = ~mclk;
	fip_host dut (.mclk, .reset, .req, .op, .group_in, .addr_in, .wdata_in, .hv_method, .temp_unprotect,
		.data_lines_in(bus), .busy, .done, .result, .protected_flag, .factory_locked, .region_active,
		.addr_pin, .data_lines_out, .data_lines_oe, .chip_en_n, .out_en_n, .write_en_n,
		.elevated_select_level, .reset_elevated, .flash_reset_n);
	fip_flash_model #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .PROT_INIT(32'h0000_0005), .SER_SEED(SD)) u_flash (
		.addr(addr_pin), .din(bus), .ce_n(chip_en_n), .oe_n(out_en_n), .we_n(write_en_n),
		.elev(elevated_select_level), .rst_n(flash_reset_n), .q(mq));
	task print_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hold the request until taken, then wait for its done pulse
	task run(input [2:0] o, input [4:0] g, input h, input [22:0] a);
		integer n;
		begin
			n = 0;
			{op, group_in, hv_method, addr_in, req} = {o, g, h, a, 1'b1};
			while (busy !== 1'b1 && n < 20)
			begin
				@(posedge mclk);
				#1 n++;
			end
			req = 0;
			while (done !== 1'b1 && n < 200)
			begin
				@(posedge mclk);
				#1 n++;
			end
			`CHK(done, 1'b1)
		end
	endtask
	// hang guard, ops take well under a hundred cycles each
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		#1 reset = 0;
		@(posedge mclk);
		#1;
		for (i = 0; i < 11; i++)
		begin
			run(rows[i][16:14], rows[i][13:9], rows[i][8], {rows[i][13:9], 18'h00012});
			`CHK(result, rows[i][7:0])
			if (rows[i][16:14] == 3'h2) `CHK(protected_flag, rows[i][7])
			if (rows[i][16:14] == 3'h3) `CHK(factory_locked, rows[i][7])
		end
		run(3'h4, 0, 0, 0);
		`CHK(region_active, 1'b1)
		run(3'h6, 0, 0, 23'h000003);
		`CHK(result, SD ^ 8'h03)
		run(3'h6, 0, 0, 23'h010003);
		`CHK(result, 8'h03)
		run(3'h7, 0, 0, 0);
		run(3'h6, 0, 0, 23'h000003);
		`CHK(result, 8'h03)
		run(3'h4, 0, 0, 0);
		run(3'h5, 0, 0, 0);
		run(3'h6, 0, 0, 23'h000003);
		`CHK(result, 8'h03)
		run(3'h4, 0, 0, 0);
		reset = 1;
		@(posedge mclk);
		#1 `CHK({flash_reset_n, region_active, write_en_n, out_en_n}, 4'h3)
		reset = 0;
		@(posedge mclk);
		#1 run(3'h6, 0, 0, 23'h000003);
		`CHK(result, 8'h03)
		temp_unprotect = 1;
		@(posedge mclk);
		#1 `CHK(reset_elevated, 1'b1)
		temp_unprotect = 0;
		@(posedge mclk);
		#1 `CHK(reset_elevated, 1'b0)
		print_verdict;
	end
endmodule
`default_nettype wire
